// *** hdl/iowake_defines.vh ***
// Constants shared by the interrupt option and low-power wake block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef IOWAKE_DEFINES_VH
`define IOWAKE_DEFINES_VH

// Register byte addresses on the register bus.
`define IOW_ADDR_OPTION 8'hc8
`define IOW_ADDR_STATUS 8'hcc

// Interrupt option register reset value and used field positions.
`define IOW_OPTION_RESET 8'h00
`define IOW_OPTION_USED 8'h70
`define IOW_BIT_LEVEL_EDGE 6
`define IOW_BIT_EDGE_POL 5
`define IOW_BIT_GLOBAL_EN 4

// Vector numbers presented to the core.
`define IOW_VEC_NMI 3'h0
`define IOW_VEC_SRC1 3'h1
`define IOW_VEC_SRC2 3'h2
`define IOW_VEC_SRC3 3'h3
`define IOW_VEC_SRC4 3'h4

// Core execution modes as tracked by this block.
`define IOW_MODE_NORMAL 2'h0
`define IOW_MODE_IRQ 2'h1
`define IOW_MODE_NMI 2'h2

// Default oscillator stabilisation wait after a wake from stop, in core cycles.
`define IOW_STAB_CYCLES 16'h0010

// Bus response codes.
`define IOW_RESP_OKAY 2'h0
`define IOW_RESP_SLVERR 2'h2

`endif

// *** hdl/iow_edge_latch.v ***
// Edge latch for one interrupt line: stores the first selected edge until cleared.
// Assumes the line is already synchronous to the clock and idles high.
`timescale 1ns/10ps
module iow_edge_latch (
   // Clock, reset and freeze.
   input wire core_clk,
   input wire reset_n,
   input wire clkEn,
   // Line and configuration.
   input wire lineIn,
   input wire risingSel,
   input wire armEn,
   // Clear at routine start.
   input wire clearIn,
   // Stored request.
   output reg flag_r
);

   reg prevLine_r;
   wire edgeSeen;

   // Pick the edge the configuration asks for.
   assign edgeSeen = risingSel ? (lineIn & ~prevLine_r) : (~lineIn & prevLine_r);

   // A new edge in the clear cycle wins, so no event is lost; extra edges merge into one.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         prevLine_r <= 1'b1;
         flag_r <= 1'b0;
      end else if (clkEn) begin
         prevLine_r <= lineIn;
         if (edgeSeen && armEn) begin
            flag_r <= 1'b1;
         end else if (clearIn || !armEn) begin
            flag_r <= 1'b0;
         end
      end
   end

endmodule // iow_edge_latch

// *** hdl/iow_wake_ctrl.v ***
// Interrupt option register, request priority and wait/stop wake control.
// Assumes a core that pulses instruction-end, return, wait and stop strobes on core_clk.
//
// Summary of operation
// - Option register is write only; reads give zero, so read-modify-write fails.
// - Any reset clears the option register to zero.
// - Option bit 7 and bits 3 to 0 are ignored on write.
// - Bit 6 set makes source 1 level sensitive, clear makes it edge sensitive.
// - Bit 5 selects which edge of source 2 raises a request.
// - Bit 5 set means rising edges on source 2, clear means falling edges.
// - Bit 4 enables all sources; clear blocks all but the non-maskable one.
// - With bit 4 clear the non-maskable request is served but never wakes.
// - Timer overflow and converter done, each under its enable, request vector 4.
// - Reload timer overflow, compare and input edge, each enabled, request vector 3.
// - Edge sources latch the first edge and clear when their routine starts.
// - Fixed priority: non-maskable first, then sources 1 down to 4.
// - Wait halts instructions at once; clock, peripherals and contents stay.
// - Wake from wait resumes with no stabilisation delay.
// - Pin or watchdog reset ends wait or stop through normal reset.
// - Stop needs watchdog off; stops oscillator until external interrupt or reset.
// - Wake from stop waits an oscillator stabilisation delay before running.
// - Sleeping in main code: waking interrupt is served, then code continues.
// - Sleeping in non-maskable routine: any interrupt wakes, mode stays non-maskable.
// - Sleeping in maskable routine: maskable wake finishes that routine first.
// - Non-maskable wake inside a maskable routine runs first, then routine resumes.
// - With watchdog active the stop instruction acts as wait.
// - With bit 4 clear, wait or stop ends only by reset.
// - Wait or stop has no effect while an enabled request is pending.
// - Service and wake leave the oscillator source selection untouched.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "iowake_defines.vh"
module iow_wake_ctrl #(
   parameter PA_W = 8,
   parameter PB_W = 8,
   parameter PC_W = 8,
   parameter STAB_W = 16,
   parameter [STAB_W-1:0] STAB_CYCLES = `IOW_STAB_CYCLES
) (
   // Clock, reset and freeze.
   input wire core_clk,
   input wire reset_n,
   input wire clkEn,
   // AXI4-Lite write address and data.
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response.
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read.
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // External lines, active low, with the port option and data settings that arm them.
   input wire nmiPin_n,
   input wire [PA_W-1:0] portAPins,
   input wire [PA_W-1:0] portAOption,
   input wire [PA_W-1:0] portAData,
   input wire [PB_W-1:0] portBPins,
   input wire [PB_W-1:0] portBOption,
   input wire [PB_W-1:0] portBData,
   input wire [PC_W-1:0] portCPins,
   input wire [PC_W-1:0] portCOption,
   input wire [PC_W-1:0] portCData,
   // Peripheral flags and their enables.
   input wire timerZeroFlag,
   input wire timerIrqEnable,
   input wire converterDoneFlag,
   input wire converterIrqEnable,
   input wire reloadOverflowFlag,
   input wire reloadOverflowIrqEnable,
   input wire compareMatchFlag,
   input wire compareIrqEnable,
   input wire inputEdgeFlag,
   input wire inputEdgeIrqEnable,
   // Watchdog state.
   input wire watchdogActive,
   // Core strobes.
   input wire instrEnd,
   input wire retiExec,
   input wire waitExec,
   input wire stopExec,
   // Core controls.
   output reg vectorTake_r,
   output reg [2:0] vectorNum_r,
   output reg coreHalt_r,
   output reg oscStop_r,
   output reg wakePulse_r,
   output reg [1:0] coreMode_r
);

   localparam PWR_RUN = 2'h0;
   localparam PWR_WAIT = 2'h1;
   localparam PWR_STOP = 2'h2;
   localparam PWR_STAB = 2'h3;

   reg [7:0] option_r;
   reg [1:0] savedMode_r;
   reg [1:0] pwr_r;
   reg [1:0] pwr_nxt;
   reg [STAB_W-1:0] stabCnt_r;
   reg [STAB_W-1:0] stabCnt_nxt;
   reg awHeld_r;
   reg wHeld_r;
   reg [7:0] awAddr_r;
   reg [31:0] wData_r;
   reg [3:0] wStrb_r;
   wire levelSel;
   wire edgePol;
   wire globalEn;
   wire line1;
   wire line2;
   wire nmiFlag;
   wire src1Flag;
   wire src2Flag;
   wire req1;
   wire req2;
   wire req3;
   wire req4;
   wire anyMask;
   wire nmiServ;
   wire maskServ;
   wire enabledPending;
   wire wakeWait;
   wire wakeStop;
   wire takeNow;
   reg [2:0] vecSel;
   wire [31:0] statusWord;

   // Option fields.
   assign levelSel = option_r[`IOW_BIT_LEVEL_EDGE];
   assign edgePol = option_r[`IOW_BIT_EDGE_POL];
   assign globalEn = option_r[`IOW_BIT_GLOBAL_EN];

   // A port line goes low when any pin set for interrupt input is low.
   assign line1 = (&(portAPins | ~(portAOption & ~portAData))) &
                  (&(portBPins | ~(portBOption & ~portBData)));
   assign line2 = &(portCPins | ~(portCOption & ~portCData));

   // Non-maskable source: falling edge on its pin, latched.
   iow_edge_latch u_nmiLatch (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .lineIn(nmiPin_n),
      .risingSel(1'b0),
      .armEn(1'b1),
      .clearIn(takeNow && nmiServ),
      .flag_r(nmiFlag)
   );

   // Source 1 latch, armed only in edge mode; falling edge.
   iow_edge_latch u_src1Latch (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .lineIn(line1),
      .risingSel(1'b0),
      .armEn(~levelSel),
      .clearIn(takeNow && !nmiServ && vecSel == `IOW_VEC_SRC1),
      .flag_r(src1Flag)
   );

   // Source 2 latch, always edge; polarity from the option register.
   iow_edge_latch u_src2Latch (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .lineIn(line2),
      .risingSel(edgePol),
      .armEn(1'b1),
      .clearIn(takeNow && !nmiServ && vecSel == `IOW_VEC_SRC2),
      .flag_r(src2Flag)
   );

   // Level requests are not stored, so the requester must hold its line until sampled.
   assign req1 = levelSel ? ~line1 : src1Flag;
   assign req2 = src2Flag;
   assign req3 = (reloadOverflowFlag & reloadOverflowIrqEnable) | (compareMatchFlag & compareIrqEnable) |
                 (inputEdgeFlag & inputEdgeIrqEnable);
   assign req4 = (timerZeroFlag & timerIrqEnable) | (converterDoneFlag & converterIrqEnable);
   assign anyMask = req1 | req2 | req3 | req4;

   // Service eligibility: the non-maskable source ignores the global enable.
   assign nmiServ = nmiFlag && coreMode_r != `IOW_MODE_NMI;
   assign maskServ = globalEn && anyMask && coreMode_r == `IOW_MODE_NORMAL;
   assign enabledPending = nmiServ | maskServ;
   assign takeNow = instrEnd && pwr_r == PWR_RUN && enabledPending;

   // Wake needs the global enable even for the non-maskable source.
   assign wakeWait = globalEn && (nmiFlag | anyMask);
   // Only external lines can wake with the oscillator stopped.
   assign wakeStop = globalEn && (nmiFlag | req1 | req2);

   // Fixed priority among the sources.
   always @* begin
      vecSel = `IOW_VEC_SRC4;
      if (nmiServ) begin
         vecSel = `IOW_VEC_NMI;
      end else if (req1) begin
         vecSel = `IOW_VEC_SRC1;
      end else if (req2) begin
         vecSel = `IOW_VEC_SRC2;
      end else if (req3) begin
         vecSel = `IOW_VEC_SRC3;
      end
   end

   // Vector hand-off and mode tracking; a non-maskable entry remembers the mode it left.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         vectorTake_r <= 1'b0;
         vectorNum_r <= `IOW_VEC_NMI;
         coreMode_r <= `IOW_MODE_NORMAL;
         savedMode_r <= `IOW_MODE_NORMAL;
      end else if (clkEn) begin
         vectorTake_r <= takeNow;
         if (takeNow) begin
            vectorNum_r <= vecSel;
            if (nmiServ) begin
               savedMode_r <= coreMode_r;
               coreMode_r <= `IOW_MODE_NMI;
            end else begin
               coreMode_r <= `IOW_MODE_IRQ;
            end
         end else if (retiExec) begin
            if (coreMode_r == `IOW_MODE_NMI) begin
               coreMode_r <= savedMode_r;
            end else begin
               coreMode_r <= `IOW_MODE_NORMAL;
            end
         end
      end
   end

   // Low-power state; entry is refused while something serviceable is pending.
   always @* begin
      pwr_nxt = pwr_r;
      stabCnt_nxt = stabCnt_r;
      case (pwr_r)
         PWR_RUN: begin
            if (stopExec && !enabledPending && !watchdogActive) begin
               pwr_nxt = PWR_STOP;
            end else if ((waitExec || stopExec) && !enabledPending) begin
               pwr_nxt = PWR_WAIT;
            end
         end
         PWR_WAIT: begin
            if (wakeWait) begin
               pwr_nxt = PWR_RUN;
            end
         end
         PWR_STOP: begin
            if (wakeStop) begin
               pwr_nxt = PWR_STAB;
               stabCnt_nxt = STAB_CYCLES;
            end
         end
         PWR_STAB: begin
            if (stabCnt_r <= {{(STAB_W-1){1'b0}}, 1'b1}) begin
               pwr_nxt = PWR_RUN;
               stabCnt_nxt = {STAB_W{1'b0}};
            end else begin
               stabCnt_nxt = stabCnt_r - {{(STAB_W-1){1'b0}}, 1'b1};
            end
         end
         default: begin
            pwr_nxt = PWR_RUN;
         end
      endcase
   end

   // Synchronous reset (pin or watchdog) returns straight to run through the normal sequence.
   // Only the oscillator enable is driven; its source selection lives elsewhere and is never touched.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         pwr_r <= PWR_RUN;
         stabCnt_r <= {STAB_W{1'b0}};
         coreHalt_r <= 1'b0;
         oscStop_r <= 1'b0;
         wakePulse_r <= 1'b0;
      end else if (clkEn) begin
         pwr_r <= pwr_nxt;
         stabCnt_r <= stabCnt_nxt;
         coreHalt_r <= pwr_nxt != PWR_RUN;
         oscStop_r <= pwr_nxt == PWR_STOP;
         wakePulse_r <= pwr_r != PWR_RUN && pwr_nxt == PWR_RUN;
      end
   end

   // Write channel: address and data are accepted in either order, then answered once.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IOW_RESP_OKAY;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         option_r <= `IOW_OPTION_RESET;
      end else if (clkEn) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!awHeld_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!wHeld_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_r[7:2] == `IOW_ADDR_OPTION >> 2) begin
               s_axi_bresp <= `IOW_RESP_OKAY;
               if (wStrb_r[0]) begin
                  option_r <= wData_r[7:0] & `IOW_OPTION_USED;
               end
            end else if (awAddr_r[7:2] == `IOW_ADDR_STATUS >> 2) begin
               s_axi_bresp <= `IOW_RESP_OKAY;
            end else begin
               s_axi_bresp <= `IOW_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Status word: stored requests, level lines, core mode and power state.
   assign statusWord = {22'h00_0000, pwr_r, coreMode_r, req4, req3, req2, req1, nmiFlag, globalEn};

   // Read channel: the option register reads as zero, so software must keep a copy.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `IOW_RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[7:2] == `IOW_ADDR_OPTION >> 2) begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `IOW_RESP_OKAY;
            end else if (s_axi_araddr[7:2] == `IOW_ADDR_STATUS >> 2) begin
               s_axi_rdata <= statusWord;
               s_axi_rresp <= `IOW_RESP_OKAY;
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `IOW_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // iow_wake_ctrl

// *** tb/iow_wake_chk.sv ***
// Checker for the wake controller: vector, mode and low-power relations.
// Assumes a bind onto iow_wake_ctrl and a stabilisation count of at least 3.
`timescale 1ns/10ps
`include "iowake_defines.vh"
module iow_wake_chk (
   // Clock and reset.
   input wire core_clk,
   input wire reset_n,
   // Write channels, watched to shadow the global enable.
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Inputs that cause wake or entry.
   input wire timerZeroFlag,
   input wire timerIrqEnable,
   input wire watchdogActive,
   input wire stopExec,
   // Core controls.
   input wire vectorTake_r,
   input wire [2:0] vectorNum_r,
   input wire coreHalt_r,
   input wire oscStop_r,
   input wire wakePulse_r,
   input wire [1:0] coreMode_r
);
   reg [7:0] wrAddr_r;
   reg [31:0] wrData_r;
   reg globalShadow_r;
   reg waitState_r;

   // The shadow lags the real enable by a cycle or two, so properties only use it well after a write.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         wrAddr_r <= 8'h00;
         wrData_r <= 32'h0;
         globalShadow_r <= 1'b0;
         waitState_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wrAddr_r <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wrData_r <= s_axi_wdata;
         if (s_axi_bvalid && s_axi_bready && wrAddr_r == `IOW_ADDR_OPTION) globalShadow_r <= wrData_r[4];
         if ($rose(coreHalt_r)) waitState_r <= !oscStop_r;
         else if (!coreHalt_r) waitState_r <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_wakeup;
      !coreHalt_r && wakePulse_r ##1 !wakePulse_r;
   endsequence
   sequence s_stabilise;
      coreHalt_r [*3];
   endsequence

   a_osc_halt: assert property (oscStop_r |-> coreHalt_r)
      else $error("oscillator stopped while core runs");
   a_stop_wait: assert property (stopExec && watchdogActive && !coreHalt_r |=> !oscStop_r)
      else $error("stop with watchdog active stopped the oscillator");
   a_wake_pulse: assert property (wakePulse_r |-> !coreHalt_r && $past(coreHalt_r))
      else $error("wake pulse without a halt ending");
   a_stab_delay: assert property ($fell(oscStop_r) |-> s_stabilise)
      else $error("core released too soon after stop");
   a_wait_fast: assert property (waitState_r && coreHalt_r && globalShadow_r && timerZeroFlag
      && timerIrqEnable |=> s_wakeup)
      else $error("wait wake not immediate");
   a_sleep_locked: assert property (coreHalt_r && !globalShadow_r |=> coreHalt_r)
      else $error("core woke with interrupts disabled");
   a_mask_global: assert property (vectorTake_r && vectorNum_r != `IOW_VEC_NMI |-> globalShadow_r)
      else $error("maskable vector taken while disabled");
   a_nmi_mode: assert property (vectorTake_r && vectorNum_r == `IOW_VEC_NMI |-> coreMode_r == `IOW_MODE_NMI)
      else $error("non-maskable take without its mode");
   a_irq_mode: assert property (vectorTake_r && vectorNum_r != `IOW_VEC_NMI
      |-> coreMode_r == `IOW_MODE_IRQ ##1 !vectorTake_r)
      else $error("maskable take without interrupt mode");
endmodule // iow_wake_chk

bind iow_wake_ctrl iow_wake_chk i_chk (.*);

// *** tb/iow_core_model.sv ***
// Behavioural core: ends an instruction every fourth running cycle, returns one instruction after a take.
// Assumes the wake controller's halt and take outputs on the same clock.
`timescale 1ns/10ps
module iow_core_model (
   // Clock and reset.
   input wire core_clk,
   input wire reset_n,
   // Bench control and controller outputs.
   input wire runEn,
   input wire coreHalt_r,
   input wire vectorTake_r,
   // Strobes to the controller.
   output reg instrEnd_r,
   output reg retiExec_r
);
   reg [1:0] phase_r;
   reg [1:0] depth_r;

   // A halted core neither ends instructions nor returns, as a real one would stand still.
   // Returns are counted, since a non-maskable entry may sit on top of a maskable routine.
   always @(posedge core_clk) begin
      if (!reset_n) begin
         phase_r <= 2'h0;
         instrEnd_r <= 1'b0;
         retiExec_r <= 1'b0;
         depth_r <= 2'h0;
      end else begin
         instrEnd_r <= runEn && !coreHalt_r && phase_r == 2'h3;
         retiExec_r <= 1'b0;
         if (!coreHalt_r) phase_r <= phase_r + 2'h1;
         if (vectorTake_r) depth_r <= depth_r + 2'h1;
         else if (depth_r != 2'h0 && runEn && !coreHalt_r && phase_r == 2'h1) begin
            retiExec_r <= 1'b1;
            depth_r <= depth_r - 2'h1;
         end
      end
   end
endmodule // iow_core_model

// *** tb/testbench.sv ***
// Self-checking bench for the wake controller with a behavioural core.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps
`include "iowake_defines.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   localparam [15:0] STAB = 16'h0003;
   logic core_clk, reset_n, clkEn, runEn, instrEnd, retiExec, waitExec, stopExec, watchdogActive, nmiPin_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, coreMode_r;
   logic timerZeroFlag, timerIrqEnable, converterDoneFlag, converterIrqEnable, reloadOverflowFlag;
   logic reloadOverflowIrqEnable, compareMatchFlag, compareIrqEnable, inputEdgeFlag, inputEdgeIrqEnable;
   logic [7:0] portAPins, portAOption, portAData, portBPins, portBOption, portBData, portCPins, portCOption, portCData;
   logic vectorTake_r, coreHalt_r, oscStop_r, wakePulse_r;
   logic [2:0] vectorNum_r;
   integer err_total, samples_checked, cnt;

   iow_wake_ctrl #(.STAB_CYCLES(STAB)) i_dut (.*);
   iow_core_model i_core (.core_clk(core_clk), .reset_n(reset_n), .runEn(runEn), .coreHalt_r(coreHalt_r),
      .vectorTake_r(vectorTake_r), .instrEnd_r(instrEnd), .retiExec_r(retiExec));

   // Clock and an overall limit so that a hang still reaches the verdict.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #3000000;
      err_total++;
      report_and_stop;
   end

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task tmo;
      err_total++;
      $display("unexpected handshake expected 1 seen 0");
      report_and_stop;
   endtask
   task ticks(input integer k);
      repeat (k) @(posedge core_clk);
   endtask
   // Bus master: valid and payload hold until their own ready is sampled.
   task axi_wr(input [7:0] a, input [31:0] d);
      integer k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
         if (k > 100) tmo;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask
   task axi_rd(input [7:0] a);
      integer k;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
         if (k > 100) tmo;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask
   // Waits for the next vector take and compares its number.
   task wait_take(input [2:0] v);
      integer k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
         if (k > 200) tmo;
      end while (vectorTake_r !== 1'b1);
      `CHK("vector", v, vectorNum_r)
   endtask
   task count_takes(input integer cyc);
      cnt = 0;
      repeat (cyc) begin
         @(posedge core_clk);
         if (vectorTake_r === 1'b1) cnt++;
      end
   endtask
   task wake_time;
      cnt = 0;
      do begin
         @(posedge core_clk);
         cnt++;
         if (cnt > 100) tmo;
      end while (wakePulse_r !== 1'b1);
   endtask
   task strobe(input integer sel);
      if (sel == 0) waitExec <= 1'b1;
      else stopExec <= 1'b1;
      @(posedge core_clk);
      waitExec <= 1'b0;
      stopExec <= 1'b0;
      ticks(2);
   endtask

   // Main sequence; pins idle high, pin 0 of each port is armed for interrupts.
   initial begin
      {reset_n, runEn, waitExec, stopExec, watchdogActive, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 8'h00;
      {s_axi_arvalid, s_axi_rready, timerZeroFlag, converterDoneFlag, reloadOverflowFlag} = 5'h00;
      {compareMatchFlag, inputEdgeFlag, portAData, portBData, portCData} = 26'h0;
      {clkEn, nmiPin_n, timerIrqEnable, converterIrqEnable, reloadOverflowIrqEnable} = 5'h1f;
      {compareIrqEnable, inputEdgeIrqEnable} = 2'h3;
      {portAPins, portBPins, portCPins, portAOption, portBOption, portCOption} = 48'hffffff010101;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h000000000000f;
      err_total = 0;
      samples_checked = 0;
      ticks(20);
      reset_n <= 1'b1;
      axi_rd(`IOW_ADDR_STATUS);
      `CHK("status", 32'h0, rd)
      axi_rd(`IOW_ADDR_OPTION);
      `CHK("option read", 34'h0, {rsp, rd})
      axi_rd(8'h10);
      `CHK("unmapped", `IOW_RESP_SLVERR, rsp)
      axi_wr(`IOW_ADDR_OPTION, 32'hffffff8f);
      axi_rd(`IOW_ADDR_STATUS);
      `CHK("unused bits", 32'h0, rd)
      axi_wr(`IOW_ADDR_OPTION, 32'h10);
      axi_rd(`IOW_ADDR_STATUS);
      `CHK("enable", 32'h1, rd)
      {nmiPin_n, portAPins, portCPins, reloadOverflowFlag, converterDoneFlag} <= 19'h3fbfb;
      @(posedge core_clk);
      nmiPin_n <= 1'b1;
      axi_rd(`IOW_ADDR_STATUS);
      `CHK("pending", 32'h3f, rd)
      runEn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wait_take(3'(i));
         if (i == 3) reloadOverflowFlag <= 1'b0;
         if (i == 4) converterDoneFlag <= 1'b0;
      end
      {portAPins, portCPins, runEn} <= 17'h1fffe;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         portBPins <= portBPins ^ 8'h01;
      end
      runEn <= 1'b1;
      count_takes(60);
      `CHK("stored edges", 1, cnt)
      axi_wr(`IOW_ADDR_OPTION, 32'h30);
      portCPins <= 8'hfe;
      count_takes(40);
      `CHK("falling ignored", 0, cnt)
      portCPins <= 8'hff;
      count_takes(40);
      `CHK("rising taken", 1, cnt)
      axi_wr(`IOW_ADDR_OPTION, 32'h50);
      portAPins <= 8'hfe;
      count_takes(60);
      `CHK("level repeats", 1'b1, cnt > 1)
      portAPins <= 8'hff;
      ticks(8);
      count_takes(40);
      `CHK("level released", 0, cnt)
      axi_wr(`IOW_ADDR_OPTION, 32'h10);
      strobe(0);
      `CHK("wait state", 2'b10, {coreHalt_r, oscStop_r})
      timerZeroFlag <= 1'b1;
      wake_time;
      `CHK("wait wake", 2, cnt)
      wait_take(`IOW_VEC_SRC4);
      timerZeroFlag <= 1'b0;
      strobe(1);
      `CHK("stop state", 2'b11, {coreHalt_r, oscStop_r})
      nmiPin_n <= 1'b0;
      @(posedge core_clk);
      nmiPin_n <= 1'b1;
      wake_time;
      `CHK("stop wake", 1'b1, cnt > STAB)
      wait_take(`IOW_VEC_NMI);
      watchdogActive <= 1'b1;
      strobe(1);
      `CHK("stop as wait", 2'b10, {coreHalt_r, oscStop_r})
      timerZeroFlag <= 1'b1;
      wait_take(`IOW_VEC_SRC4);
      {timerZeroFlag, watchdogActive} <= 2'b00;
      ticks(10);
      {timerZeroFlag, runEn} <= 2'b10;
      strobe(0);
      `CHK("wait refused", 1'b0, coreHalt_r)
      runEn <= 1'b1;
      wait_take(`IOW_VEC_SRC4);
      timerZeroFlag <= 1'b0;
      axi_wr(`IOW_ADDR_OPTION, 32'h00);
      strobe(0);
      nmiPin_n <= 1'b0;
      @(posedge core_clk);
      nmiPin_n <= 1'b1;
      ticks(20);
      `CHK("locked", 1'b1, coreHalt_r)
      reset_n <= 1'b0;
      ticks(2);
      reset_n <= 1'b1;
      ticks(2);
      `CHK("reset exit", 1'b0, coreHalt_r)
      axi_rd(`IOW_ADDR_STATUS);
      `CHK("status", 32'h0, rd)
      report_and_stop;
   end
endmodule // testbench
